// [vmc_ctrl.sv]
`timescale 1ns/1ps
`include "vmc_regs.svh"
// Overview of operation
// [R01] entry fails on unsupported fixed bits
// [R02] fixed-bit violation by cr writes faults
// [R03] transitions never load unsupported fixed bits; the warm-restart exit loads host state unchecked
// [R04] pe ne pg and enable bit required
// [R05] entry fails in address mask mode
// [R06] address mask interrupts blocked while operating
// [R07] warm restart blocked in root operation
// [R08] warm restart in guest causes exit
// [R09] software supplies 4k aligned pointers
// [R10] software keeps pointer high bits clear
// [R11] many active structures, one current
// [R12] load makes structure active and current
// [R13] deactivate makes structure inactive, forgotten
// [R14] software deactivates before leaving
// [R15] entry, field and store use current
// [R16] store writes current pointer out
// [R17] region: revision, abort word, data
// [R18] revision never written; mismatch fails load
// [R19] software writes revision before use
// [R20] abort writes non-zero abort word
// [R21] exits save guest, load host state; the XFER_ABORT exit strobes neither SAVE_GUEST nor LOAD_HOST
// [R22] exit information filled, read-only
// [R23] entry undefined when enable bit clear
// [R24] entry faults unless lock and enable
module vmc_ctrl
   import vmc_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        ARST_N,
   input  wire logic        OP_VALID,
   input  wire logic [3:0]  OP_CODE,
   input  wire logic [63:0] OP_PTR,
   input  wire logic [31:0] OP_REV,
   input  wire logic [31:0] REG_ZERO_VAL,
   input  wire logic [31:0] REG_FOUR_VAL,
   input  wire logic [31:0] REG_ZERO_NEW,
   input  wire logic [31:0] REG_FOUR_NEW,
   input  wire logic [31:0] FIXED0_REG_ZERO,
   input  wire logic [31:0] FIXED1_REG_ZERO,
   input  wire logic [31:0] FIXED0_REG_FOUR,
   input  wire logic [31:0] FIXED1_REG_FOUR,
   input  wire logic [2:0]  FEAT_CTRL,
   input  wire logic [31:0] REV_ID,
   input  wire logic [7:0]  PA_WIDTH,
   input  wire logic        ADDR_MASK_MODE,
   input  wire logic        ADDR_MASK_IRQ,
   input  wire logic        WARM_RESTART,
   input  wire logic        XFER_ABORT,
   input  wire logic [15:0] EXIT_REASON_IN,
   output logic             DONE,
   output logic [2:0]       RESULT,
   output logic [1:0]       MODE,
   output logic [63:0]      CUR_PTR,
   output logic [63:0]      STORE_DATA,
   output logic             STORE_WE,
   output logic             ABORT_WE,
   output logic [63:0]      ABORT_ADDR,
   output logic [31:0]      ABORT_DATA,
   output logic             MASK_IRQ_OUT,
   output logic             RESTART_OUT,
   output logic             GUEST_EXIT,
   output logic             SAVE_GUEST,
   output logic             LOAD_HOST,
   output logic             LOAD_GUEST,
   output logic [15:0]      EXIT_INFO,
   output logic [7:0]       ACTIVE_CNT
);
   localparam int NACT = 8;
   default clocking cb_main @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   typedef struct packed {
      vmc_mode_type mode;
      logic         done;
      vmc_res_type  res;
      logic [63:0]  cur;
      logic         cur_ok;
      logic [NACT-1:0]       act_v;
      logic [NACT-1:0][51:0] act_a;
      logic [63:0]  st_data;
      logic         st_we;
      logic         ab_we;
      logic [63:0]  ab_addr;
      logic [31:0]  ab_data;
      logic         irq_o;
      logic         rst_o;
      logic         gexit;
      logic         sv_g;
      logic         ld_h;
      logic         ld_g;
      logic [15:0]  info;
      logic [7:0]   cnt;
   } vmc_state_type;

   vmc_state_type s_q;
   vmc_state_type s_d;

   // three-stage synchronisers for the pin-like inputs
   logic [2:0] msk_m_q;
   logic [2:0] msk_i_q;
   logic [2:0] rst_i_q;
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         msk_m_q <= 3'h0;
         msk_i_q <= 3'h0;
         rst_i_q <= 3'h0;
      end else begin
         msk_m_q <= {msk_m_q[1:0], ADDR_MASK_MODE};
         msk_i_q <= {msk_i_q[1:0], ADDR_MASK_IRQ};
         rst_i_q <= {rst_i_q[1:0], WARM_RESTART};
      end
   end
   logic mask_mode;
   logic mask_irq;
   logic restart;
   logic msk_m_lvl_q;
   logic msk_i_lvl_q;
   logic rst_prev_q;
   // a level moves only once the last two stages agree
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         msk_m_lvl_q <= 1'b0;
         msk_i_lvl_q <= 1'b0;
         rst_prev_q  <= 1'b0;
      end else begin
         if (msk_m_q[2] == msk_m_q[1]) msk_m_lvl_q <= msk_m_q[2];
         if (msk_i_q[2] == msk_i_q[1]) msk_i_lvl_q <= msk_i_q[2];
         if (rst_i_q[2] == rst_i_q[1]) rst_prev_q <= rst_i_q[2];
      end
   end
   assign mask_mode = msk_m_lvl_q;
   assign mask_irq  = msk_i_lvl_q;
   assign restart = rst_i_q[2] & rst_i_q[1] & ~rst_prev_q;

   // fixed bits: forced ones and allowed ones, plus first-generation set
   function automatic logic fix_ok(input logic [31:0] v,
                                   input logic [31:0] f0,
                                   input logic [31:0] f1);
      fix_ok = ((v & f0) == f0) && ((v & ~f1) == 32'h0);
   endfunction : fix_ok

   logic [31:0] req0;
   logic [31:0] req4;
   logic        cur_fix_ok;
   logic        new_fix_ok;
   always_comb begin
      req0 = FIXED0_REG_ZERO;
      req0[`VMC_PROT_EN_BIT] = 1'b1; // R04
      req0[`VMC_NUM_ERR_BIT] = 1'b1; // R04
      req0[`VMC_PAGING_EN_BIT] = 1'b1; // R04
      req4 = FIXED0_REG_FOUR;
      req4[`VMC_VIRT_EN_BIT] = 1'b1; // R04
      cur_fix_ok = fix_ok(REG_ZERO_VAL, req0, FIXED1_REG_ZERO)
                 && fix_ok(REG_FOUR_VAL, req4, FIXED1_REG_FOUR); // R01
      new_fix_ok = fix_ok(REG_ZERO_NEW, req0, FIXED1_REG_ZERO)
                 && fix_ok(REG_FOUR_NEW, req4, FIXED1_REG_FOUR); // R02
   end

   // pointer checks and active table lookup
   logic        ptr_ok;
   logic [63:0] hi_mask;
   logic [NACT-1:0] hit;
   logic [NACT-1:0] free;
   always_comb begin
      hi_mask = (PA_WIDTH >= 8'd64) ? 64'h0 : (~64'h0 << PA_WIDTH);
      ptr_ok  = (OP_PTR[`VMC_ALIGN_BITS-1:0] == 12'h0)
              && ((OP_PTR & hi_mask) == 64'h0);
   end
   genvar gi;
   generate
      for (gi = 0; gi < NACT; gi++) begin : g_act
         assign hit[gi]  = s_q.act_v[gi] && s_q.act_a[gi] == OP_PTR[63:12];
         assign free[gi] = ~s_q.act_v[gi];
      end
   endgenerate
   logic [NACT-1:0] pick;
   assign pick = free & (~free + 8'h01); // lowest free entry only

   logic in_op;
   assign in_op = s_q.mode != VMC_MODE_OUT;

   // next-state logic for one instruction or event per cycle
   always_comb begin
      s_d = s_q;
      s_d.done  = 1'b0;
      s_d.st_we = 1'b0;
      s_d.ab_we = 1'b0;
      s_d.gexit = 1'b0;
      s_d.sv_g  = 1'b0;
      s_d.ld_h  = 1'b0;
      s_d.ld_g  = 1'b0;
      s_d.irq_o = mask_irq & ~in_op; // R06
      s_d.rst_o = restart & (s_q.mode == VMC_MODE_OUT); // R07
      if (restart && s_q.mode == VMC_MODE_GST) begin
         s_d.gexit = 1'b1; // R08
         s_d.sv_g  = 1'b1; // R21
         s_d.ld_h  = 1'b1; // R21
         s_d.info  = EXIT_REASON_IN; // R22
         s_d.mode  = VMC_MODE_ROOT;
      end else if (OP_VALID) begin
         s_d.done = 1'b1;
         s_d.res  = VMC_RES_OK;
         case (vmc_op_type'(OP_CODE))
            VMC_OP_ENTER: begin
               if (!REG_FOUR_VAL[`VMC_VIRT_EN_BIT])
                  s_d.res = VMC_RES_UD; // R23
               else if (!FEAT_CTRL[`VMC_FC_LOCK_BIT]
                        || !FEAT_CTRL[`VMC_FC_EN_BIT])
                  s_d.res = VMC_RES_GP; // R24
               else if (in_op || !cur_fix_ok || mask_mode || !ptr_ok)
                  s_d.res = VMC_RES_FAIL; // R01 R05
               else s_d.mode = VMC_MODE_ROOT;
            end
            VMC_OP_LEAVE: begin
               if (!in_op) s_d.res = VMC_RES_UD;
               else begin
                  s_d.mode   = VMC_MODE_OUT;
                  s_d.cur_ok = 1'b0;
                  s_d.cur    = `VMC_PTR_INVALID;
               end
            end
            VMC_OP_LOAD: begin
               if (!in_op) s_d.res = VMC_RES_UD;
               else if (!ptr_ok || OP_REV != REV_ID)
                  s_d.res = VMC_RES_FAIL; // R18
               else if (hit == '0 && free == '0)
                  s_d.res = VMC_RES_FAIL;
               else begin
                  s_d.cur    = OP_PTR; // R12
                  s_d.cur_ok = 1'b1;
                  if (hit == '0) begin
                     for (int i = 0; i < NACT; i++) begin
                        if (pick[i]) begin
                           s_d.act_v[i] = 1'b1; // R11
                           s_d.act_a[i] = OP_PTR[63:12];
                        end
                     end
                     s_d.cnt = s_q.cnt + 8'd1;
                  end
               end
            end
            VMC_OP_CLEAR: begin
               if (!in_op) s_d.res = VMC_RES_UD;
               else if (!ptr_ok) s_d.res = VMC_RES_FAIL;
               else begin
                  for (int i = 0; i < NACT; i++) begin
                     if (hit[i]) s_d.act_v[i] = 1'b0; // R13
                  end
                  if (hit != '0) s_d.cnt = s_q.cnt - 8'd1;
                  if (s_q.cur_ok && s_q.cur == OP_PTR) begin
                     s_d.cur_ok = 1'b0; // R13
                     s_d.cur    = `VMC_PTR_INVALID;
                  end
               end
            end
            VMC_OP_STORE: begin
               if (!in_op) s_d.res = VMC_RES_UD;
               else begin
                  s_d.st_data = s_q.cur; // R16
                  s_d.st_we   = 1'b1;
               end
            end
            VMC_OP_LAUNCH, VMC_OP_RESUME: begin
               if (s_q.mode != VMC_MODE_ROOT) s_d.res = VMC_RES_UD;
               else if (!s_q.cur_ok || !cur_fix_ok)
                  s_d.res = VMC_RES_FAIL; // R15 R03
               else begin
                  s_d.mode = VMC_MODE_GST;
                  s_d.ld_g = 1'b1; // R21
               end
            end
            VMC_OP_FREAD, VMC_OP_FWRITE: begin
               if (!in_op) s_d.res = VMC_RES_UD;
               else if (!s_q.cur_ok) s_d.res = VMC_RES_FAIL; // R15
            end
            VMC_OP_CRWRITE: begin
               if (in_op && !new_fix_ok) s_d.res = VMC_RES_GP; // R02
            end
            VMC_OP_EXIT: begin
               if (s_q.mode != VMC_MODE_GST) s_d.res = VMC_RES_FAIL;
               else if (XFER_ABORT) begin
                  s_d.ab_we   = 1'b1; // R20
                  s_d.ab_addr = s_q.cur + 64'(`VMC_ABORT_OFS); // R17
                  s_d.ab_data = `VMC_ABORT_CODE;
                  s_d.mode    = VMC_MODE_ROOT;
               end else if (!cur_fix_ok) begin
                  s_d.res = VMC_RES_FAIL; // R03
               end else begin
                  s_d.gexit = 1'b1;
                  s_d.sv_g  = 1'b1; // R21
                  s_d.ld_h  = 1'b1;
                  s_d.info  = EXIT_REASON_IN; // R22
                  s_d.mode  = VMC_MODE_ROOT;
               end
            end
            default: s_d.res = VMC_RES_UD;
         endcase
      end
   end

   // state register
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q        <= '0;
         s_q.mode   <= VMC_MODE_OUT;
         s_q.cur    <= `VMC_PTR_INVALID;
      end else begin
         s_q <= s_d;
      end
   end

   assign DONE         = s_q.done;
   assign RESULT       = s_q.res;
   assign MODE         = s_q.mode;
   assign CUR_PTR      = s_q.cur;
   assign STORE_DATA   = s_q.st_data;
   assign STORE_WE     = s_q.st_we;
   assign ABORT_WE     = s_q.ab_we;
   assign ABORT_ADDR   = s_q.ab_addr;
   assign ABORT_DATA   = s_q.ab_data;
   assign MASK_IRQ_OUT = s_q.irq_o;
   assign RESTART_OUT  = s_q.rst_o;
   assign GUEST_EXIT   = s_q.gexit;
   assign SAVE_GUEST   = s_q.sv_g;
   assign LOAD_HOST    = s_q.ld_h;
   assign LOAD_GUEST   = s_q.ld_g;
   assign EXIT_INFO    = s_q.info;
   assign ACTIVE_CNT   = s_q.cnt;

   // checks
   chk_mask_blocked: assert property (in_op |=> !MASK_IRQ_OUT) // R06
      else $error("mask irq passed");
   chk_root_restart: assert property ( // R07
      s_q.mode == VMC_MODE_ROOT |=> !RESTART_OUT)
      else $error("restart passed in root");
   chk_guest_restart: assert property ( // R08
      restart && s_q.mode == VMC_MODE_GST |=> GUEST_EXIT && MODE == 2'b01)
      else $error("restart gave no exit");
   chk_enter_ud: assert property ( // R23
      OP_VALID && OP_CODE == 4'h1 && !restart && !REG_FOUR_VAL[13]
      |=> RESULT == 3'h2) else $error("enter without enable not ud");
   chk_enter_mask: assert property ( // R05
      OP_VALID && OP_CODE == 4'h1 && mask_mode && !restart
      |=> RESULT != 3'h0) else $error("enter in mask mode ok");
   chk_load_cur: assert property ( // R12
      OP_VALID && OP_CODE == 4'h3 && !restart |=>
      RESULT != 3'h0 || CUR_PTR == $past(OP_PTR))
      else $error("load did not set current");
   chk_store_val: assert property ( // R16
      STORE_WE |-> STORE_DATA == $past(CUR_PTR))
      else $error("store data wrong");
   chk_crw_gp: assert property ( // R02
      OP_VALID && OP_CODE == 4'ha && in_op && !new_fix_ok && !restart
      |=> RESULT == 3'h3) else $error("cr write not gp");
   chk_abort_nz: assert property ( // R20
      ABORT_WE |-> ABORT_DATA != 32'h0
      && ABORT_ADDR == $past(CUR_PTR) + 64'h4) else $error("abort word bad");
   cov_enter: cover property (MODE == 2'b01);
   cov_guest: cover property (MODE == 2'b11);
   cov_exit: cover property (GUEST_EXIT);
endmodule : vmc_ctrl

// [vmc_regs.svh]
`ifndef VMC_REGS_SVH
`define VMC_REGS_SVH
// control register zero bit positions
`define VMC_PROT_EN_BIT     0
`define VMC_NUM_ERR_BIT     5
`define VMC_TASK_SW_BIT     3
`define VMC_PAGING_EN_BIT   31
// control register four bit position
`define VMC_VIRT_EN_BIT     13
// feature-control bits
`define VMC_FC_LOCK_BIT     0
`define VMC_FC_EN_BIT       2
// structure region layout, byte offsets
`define VMC_REV_OFS         12'h000
`define VMC_ABORT_OFS       12'h004
`define VMC_DATA_OFS        12'h008
// pointer alignment field width
`define VMC_ALIGN_BITS      12
// arbitrary neutral revision identifier
`define VMC_REV_ID_DEFAULT  32'h0000_0001
// default abort code written on a failed transition (non-zero)
`define VMC_ABORT_CODE      32'h0000_0001
// reset values
`define VMC_PTR_INVALID     64'hffff_ffff_ffff_ffff
`endif

// [vmc_pkg.sv]
package vmc_pkg;
   // instruction codes presented by the core
   typedef enum logic [3:0] {
      VMC_OP_NONE    = 4'h0,
      VMC_OP_ENTER   = 4'h1,
      VMC_OP_LEAVE   = 4'h2,
      VMC_OP_LOAD    = 4'h3,
      VMC_OP_STORE   = 4'h4,
      VMC_OP_CLEAR   = 4'h5,
      VMC_OP_LAUNCH  = 4'h6,
      VMC_OP_RESUME  = 4'h7,
      VMC_OP_FREAD   = 4'h8,
      VMC_OP_FWRITE  = 4'h9,
      VMC_OP_CRWRITE = 4'ha,
      VMC_OP_EXIT    = 4'hb
   } vmc_op_type;
   // result of an instruction
   typedef enum logic [2:0] {
      VMC_RES_OK   = 3'h0,
      VMC_RES_FAIL = 3'h1,
      VMC_RES_UD   = 3'h2,
      VMC_RES_GP   = 3'h3
   } vmc_res_type;
   // operating mode, gray along outside, root, guest
   typedef enum logic [1:0] {
      VMC_MODE_OUT  = 2'b00,
      VMC_MODE_ROOT = 2'b01,
      VMC_MODE_GST  = 2'b11
   } vmc_mode_type;
endpackage : vmc_pkg

// [vmc_sw_model.sv]
`timescale 1ns/1ps
// memory side of the structure regions as software prepares them
module vmc_sw_model (
   input  wire logic        clk,
   input  wire logic [63:0] ptr,
   input  wire logic [31:0] rev_id,
   input  wire logic        abort_we,
   input  wire logic [63:0] abort_addr,
   input  wire logic [31:0] abort_data,
   output logic [31:0]      rev_word,
   output logic [31:0]      abort_word,
   output logic             abort_ofs_ok
);
   logic [31:0] rev_mem [16];
   // software stamps the revision into regions 0..14, region 15 is stale
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         rev_mem[i] = (i == 15) ? ~rev_id : rev_id;
      end
   end
   // revision word sits at byte 0 of the region picked by ptr[15:12]
   assign rev_word = rev_mem[ptr[15:12]];
   // abort indicator lands at byte 4 of the current region
   always_ff @(posedge clk) begin
      if (abort_we) begin
         abort_word   <= abort_data;
         abort_ofs_ok <= (abort_addr[11:0] == 12'h004);
      end
   end
endmodule : vmc_sw_model

// [vmc_ctrl_tb.sv]
`timescale 1ns/1ps
module vmc_ctrl_tb
   import vmc_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        op_valid = 1'b0;
   logic [3:0]  op_code = 4'h0;
   logic [63:0] op_ptr = 64'h0;
   logic [31:0] reg0_val = 32'h0, reg4_val = 32'h0, reg0_new = 32'h0;
   logic [31:0] reg4_new = 32'h0, rev_id = 32'h0, crok, cr4ok;
   int          fixed_bit [3] = '{0, 5, 31};
   logic [2:0]  feat = 3'h0;
   logic        mmode = 1'b0, mirq = 1'b0, wrst = 1'b0, xab = 1'b0;
   logic [15:0] exr = 16'h0;
   logic        clr = 1'b0;
   logic        done, store_we, abort_we, mask_irq_out, restart_out;
   logic        guest_exit, save_guest, load_host, load_guest, abort_ok;
   logic [2:0]  result;
   logic [1:0]  mode;
   logic [63:0] cur_ptr, store_data, abort_addr, cur;
   logic [31:0] abort_data, op_rev, abort_word;
   logic [15:0] exit_info;
   logic [7:0]  active_cnt;
   logic [6:0]  sticky;
   logic [63:0] ptrs [10];
   int          num_errors = 0, samples_checked = 0;

   vmc_ctrl i_vmc_ctrl (.REF_CLK(ref_clk), .ARST_N(arst_n),
      .OP_VALID(op_valid), .OP_CODE(op_code), .OP_PTR(op_ptr),
      .OP_REV(op_rev), .REG_ZERO_VAL(reg0_val), .REG_FOUR_VAL(reg4_val),
      .REG_ZERO_NEW(reg0_new), .REG_FOUR_NEW(reg4_new),
      .FIXED0_REG_ZERO(32'h8000_0021), .FIXED1_REG_ZERO(32'hffff_ffff),
      .FIXED0_REG_FOUR(32'h0000_2000), .FIXED1_REG_FOUR(32'hffff_ffff),
      .FEAT_CTRL(feat), .REV_ID(rev_id),
      .PA_WIDTH(8'h24), .ADDR_MASK_MODE(mmode), .ADDR_MASK_IRQ(mirq),
      .WARM_RESTART(wrst), .XFER_ABORT(xab), .EXIT_REASON_IN(exr),
      .DONE(done), .RESULT(result), .MODE(mode), .CUR_PTR(cur_ptr),
      .STORE_DATA(store_data), .STORE_WE(store_we), .ABORT_WE(abort_we),
      .ABORT_ADDR(abort_addr), .ABORT_DATA(abort_data),
      .MASK_IRQ_OUT(mask_irq_out), .RESTART_OUT(restart_out),
      .GUEST_EXIT(guest_exit), .SAVE_GUEST(save_guest),
      .LOAD_HOST(load_host), .LOAD_GUEST(load_guest),
      .EXIT_INFO(exit_info), .ACTIVE_CNT(active_cnt));

   vmc_sw_model i_vmc_sw_model (.clk(ref_clk), .ptr(op_ptr),
      .rev_id(rev_id), .abort_we(abort_we), .abort_addr(abort_addr),
      .abort_data(abort_data), .rev_word(op_rev),
      .abort_word(abort_word), .abort_ofs_ok(abort_ok));

   // clock at 200 mhz
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // strobes collected so a one-cycle pulse is never missed
   always @(negedge ref_clk) begin
      sticky <= clr ? 7'h00 : sticky | {store_we, abort_we, restart_out,
                guest_exit, save_guest, load_host, load_guest};
   end

   task automatic check(input string nm, input logic [63:0] seen,
                        input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // aligned pointer inside a 36-bit physical space, region picked by idx
   function automatic logic [63:0] rptr(input logic [3:0] idx);
      logic [31:0] r;
      r = $urandom;
      return {32'h0, r[15:0], idx, 12'h000};
   endfunction : rptr

   task automatic clear_s();
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
   endtask : clear_s

   // one instruction, answer awaited under a bounded count
   task automatic op(input vmc_op_type c, input logic [63:0] p);
      int n;
      n = 0;
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_ptr <= p;
      clr <= 1'b1;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      clr <= 1'b0;
      #1;
      while (done !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n == 20) check("done", 1'b0, 1'b1);
      @(negedge ref_clk);
      #1;
   endtask : op

   task automatic try_enter(input logic [31:0] c0, input logic [31:0] c4,
                            input logic [2:0] f, input logic m,
                            input vmc_res_type exp);
      @(posedge ref_clk);
      reg0_val <= c0;
      reg4_val <= c4;
      feat <= f;
      mmode <= m;
      repeat (6) @(posedge ref_clk);
      op(VMC_OP_ENTER, rptr(4'he));
      check("enter result", result, exp);
   endtask : try_enter

   // watchdog well beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      test_done();
   end

   initial begin
      void'($urandom(32'h3e3b8ffb));
      rev_id = $urandom;
      crok = $urandom | 32'h8000_0021;
      cr4ok = $urandom | 32'h0000_2000;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      check("reset mode", mode, VMC_MODE_OUT);
      check("reset cur", cur_ptr, 64'hffff_ffff_ffff_ffff);
      check("reset cnt", active_cnt, 8'h00);
      $display("test reset done");
      try_enter(crok, cr4ok & ~32'h2000, 3'b000, 1'b0, VMC_RES_UD);
      try_enter(crok, cr4ok, 3'b001, 1'b0, VMC_RES_GP);
      try_enter(crok, cr4ok, 3'b100, 1'b0, VMC_RES_GP);
      try_enter(crok, cr4ok, 3'b101, 1'b1, VMC_RES_FAIL);
      foreach (ptrs[b]) begin
         if (b < 3) try_enter(crok & ~(32'h1 << fixed_bit[b]), cr4ok,
                              3'b101, 1'b0, VMC_RES_FAIL);
      end
      check("mode out", mode, VMC_MODE_OUT);
      try_enter(crok, cr4ok, 3'b101, 1'b0, VMC_RES_OK);
      check("mode root", mode, VMC_MODE_ROOT);
      try_enter(crok, cr4ok, 3'b101, 1'b0, VMC_RES_FAIL);
      $display("test enter done");
      mirq <= 1'b1;
      wrst <= 1'b1;
      clear_s();
      repeat (10) @(negedge ref_clk);
      #1;
      check("mask irq", mask_irq_out, 1'b0);
      check("restart", sticky[4:3], 2'b00);
      mirq <= 1'b0;
      wrst <= 1'b0;
      $display("test root blocking done");
      op(VMC_OP_LOAD, rptr(4'hf));
      check("bad rev", result, VMC_RES_FAIL);
      op(VMC_OP_LOAD, rptr(4'h1) | 64'h10);
      check("misaligned", result, VMC_RES_FAIL);
      op(VMC_OP_LOAD, rptr(4'h1) | (64'h1 << 40));
      check("wide ptr", result, VMC_RES_FAIL);
      check("cnt none", active_cnt, 8'h00);
      for (int i = 0; i < 9; i++) begin
         ptrs[i] = rptr(4'(i));
         op(VMC_OP_LOAD, ptrs[i]);
         check("load res", result, (i < 8) ? VMC_RES_OK : VMC_RES_FAIL);
         check("load cnt", active_cnt, 8'((i < 8) ? i + 1 : 8));
         if (i < 8) check("load cur", cur_ptr, ptrs[i]);
      end
      op(VMC_OP_CLEAR, ptrs[7]);
      check("clear cnt", active_cnt, 8'h07);
      check("clear cur", cur_ptr, 64'hffff_ffff_ffff_ffff);
      cur = rptr(4'h9);
      ptrs[7] = cur;
      op(VMC_OP_LOAD, cur);
      check("reload cur", cur_ptr, cur);
      $display("test structures done");
      reg0_new <= crok & ~32'h1;
      reg4_new <= cr4ok;
      op(VMC_OP_CRWRITE, 64'h0);
      check("reg0 pe clear", result, VMC_RES_GP);
      reg0_new <= crok;
      reg4_new <= cr4ok & ~32'h2000;
      op(VMC_OP_CRWRITE, 64'h0);
      check("reg4 ve clear", result, VMC_RES_GP);
      reg4_new <= cr4ok;
      op(VMC_OP_CRWRITE, 64'h0);
      check("cr legal", result, VMC_RES_OK);
      $display("test control writes done");
      op(VMC_OP_LAUNCH, 64'h0);
      check("launch mode", mode, VMC_MODE_GST);
      check("load guest", sticky[0], 1'b1);
      clear_s();
      wrst <= 1'b1;
      repeat (12) @(negedge ref_clk);
      #1;
      check("restart exit", sticky[4:1], 4'b0111);
      check("exit mode", mode, VMC_MODE_ROOT);
      wrst <= 1'b0;
      exr <= 16'($urandom);
      op(VMC_OP_RESUME, 64'h0);
      check("resume mode", mode, VMC_MODE_GST);
      op(VMC_OP_EXIT, 64'h0);
      check("exit strobes", sticky[3:1], 3'b111);
      check("exit info", exit_info, exr);
      op(VMC_OP_RESUME, 64'h0);
      xab <= 1'b1;
      op(VMC_OP_EXIT, 64'h0);
      xab <= 1'b0;
      check("abort we", sticky[5], 1'b1);
      check("abort addr", abort_addr, cur + 64'h4);
      check("abort nz", abort_data != 32'h0, 1'b1);
      @(posedge ref_clk);
      #1;
      check("abort word", abort_ok && abort_word != 32'h0, 1'b1);
      check("abort mode", mode, VMC_MODE_ROOT);
      $display("test guest done");
      op(VMC_OP_STORE, 64'h0);
      check("store we", sticky[6], 1'b1);
      check("store data", store_data, cur);
      for (int i = 0; i < 8; i++) begin
         op(VMC_OP_CLEAR, ptrs[i]);
      end
      check("all clear", active_cnt, 8'h00);
      op(VMC_OP_LEAVE, 64'h0);
      check("leave mode", mode, VMC_MODE_OUT);
      mirq <= 1'b1;
      wrst <= 1'b1;
      clear_s();
      repeat (10) @(negedge ref_clk);
      #1;
      check("mask irq out", mask_irq_out, 1'b1);
      check("restart out", sticky[4:3], 2'b10);
      $display("test leave done");
      test_done();
   end
endmodule : vmc_ctrl_tb
